/* rtl/csor_top.sv */
// csor top: core status and timer option registers on avalon-mm
// Operation
// - status accepts writes like any register
// - flag bits take logic result, not data
// - timeout and sleep flags ignore software writes
// - clearing status gives 000u u1uu
// - carry and digit carry are inverted borrow
// - subtract by adding twos complement
// - rotates load carry with shifted bit
// - two direct bank bits pick bank
// - expiry flag set power-up/clear/sleep, cleared timeout
// - sleep flag set power-up/clear, cleared sleep
// - zero flag follows zero result
// - digit carry from low nibble
// - carry from most significant bit
// - pullup_disable turns off all pull-ups
// - ext_irq_edge selects rising or falling edge
// - counter_clk_sel picks pin or instruction clock
// - counter_edge_sel picks pin falling or rising
// - prescaler_owner gives prescaler to watchdog
// - prescaler_rate sets power of two division
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`include "csor_cfg.svh"
`default_nettype none
module csor_top (
   input  wire logic        clk,
   input  wire logic        rst_b,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // core events, same clock
   input  wire logic        evt_wdt_clear,
   input  wire logic        evt_sleep,
   input  wire logic        evt_wdt_timeout,
   input  wire logic        wdt_base_tick,
   input  wire logic [7:0]  pullup_enable_bits,
   // pins, asynchronous
   input  wire logic        counter_input_pin,
   input  wire logic        ext_irq_pin,
   // outputs to the surrounding logic
   output logic [7:0]       pullup_en,
   output logic             ext_irq_event,
   output logic             tick_counter_inc,
   output logic             watchdog_tick,
   output logic [1:0]       direct_bank_sel,
   output logic             indirect_bank_sel
);
   import csor_pkg::*;

   // status fields kept apart so each owner has one process
   logic [2:0]  bank_ff;      // indirect and direct bank select
   logic        to_ff;        // watchdog_expiry_flag
   logic        pd_ff;        // sleep_entered_flag
   logic [2:0]  flag_ff;      // zero, nibble overflow, msb out
   logic [7:0]  option_ff;    // timer_option_config
   logic [7:0]  work_ff;      // working operand
   logic [7:0]  file_ff;      // scratch file operand
   logic [7:0]  result_ff;    // last datapath result
   logic        wait_ff;      // waitrequest state
   logic [31:0] rdata_ff;     // read data holding
   logic [7:0]  status;       // assembled status byte
   logic        take;         // bus request accepted this edge
   logic        wr_lo;        // low byte lane written
   logic        exec;         // command write executes an op
   logic        dest_st;      // command targets the status register
   logic [31:0] rd_mux;       // read data selection
   logic [1:0]  div_ff;       // instruction clock divider
   logic        instr_tick;   // instruction cycle pulse
   logic [2:0]  cpin_ff;      // counter pin sync and history
   logic [2:0]  ipin_ff;      // irq pin sync and history
   logic [2:0]  arm_ff;       // history valid after reset
   logic        cpin_edge;    // selected counter pin edge
   logic        irq_edge;     // selected irq pin edge
   logic        src_tick;     // tick counter source pulse
   logic        irq_ev_ff;    // registered irq edge pulse
   logic [7:0]  pu_ff;        // registered pull-up enables
   logic [7:0]  st_wr;        // status byte as the op writes it

   csor_alu_if alu_bus ();

   assign status = {bank_ff, to_ff, pd_ff, flag_ff};
   assign take   = (avs_read || avs_write) && !wait_ff;
   assign wr_lo  = take && avs_write && avs_byteenable[0];
   assign exec   = wr_lo && (avs_address == `CSOR_OFS_CMD);
   assign dest_st = avs_writedata[`CSOR_CMD_DEST];

   // datapath inputs: op, bit and literal from the command word, operands from registers
   always_comb begin
      alu_bus.op      = csor_op_t'(avs_writedata[`CSOR_CMD_OP_HI:0]);
      alu_bus.work    = work_ff;
      alu_bus.bit_idx = avs_writedata[`CSOR_CMD_BIT_HI:`CSOR_CMD_BIT_LO];
      alu_bus.c_in    = flag_ff[`CSOR_ST_C];
      // literal ops use the literal, file ops use status or scratch
      if (alu_bus.op == CSOR_OP_ADD_LIT ||
          alu_bus.op == CSOR_OP_SUB_LIT) begin
         alu_bus.src = avs_writedata[`CSOR_CMD_LIT_HI:`CSOR_CMD_LIT_LO];
      end else if (dest_st) begin
         alu_bus.src = status;
      end else begin
         alu_bus.src = file_ff;
      end
   end

   csor_flag_alu u_alu (
      .a (alu_bus.alu)
   );

   // status byte that an op aimed at status would store
   always_comb begin
      st_wr = alu_bus.res;
      // any flag-touching op blocks the data write to flags
      if (alu_bus.aff != 3'h0) begin
         for (int i = 0; i < 3; i++) begin
            st_wr[i] = alu_bus.aff[i] ? alu_bus.flags[i] : flag_ff[i];
         end
      end
   end

   // ---- avalon slave handshake ----
   // one wait cycle per access keeps read data a pure flop
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_ff <= 1'b1;
      end else if (wait_ff && (avs_read || avs_write)) begin
         wait_ff <= 1'b0;     // answer on next edge
      end else begin
         wait_ff <= 1'b1;     // request taken or idle
      end
   end

   // read data selection, unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address)
         `CSOR_OFS_STATUS: rd_mux = {24'h00_0000, status};
         `CSOR_OFS_OPTION: rd_mux = {24'h00_0000, option_ff};
         `CSOR_OFS_WORK:   rd_mux = {24'h00_0000, work_ff};
         `CSOR_OFS_FILE:   rd_mux = {24'h00_0000, file_ff};
         `CSOR_OFS_RESULT: rd_mux = {24'h00_0000, result_ff};
         default:          rd_mux = 32'h0000_0000;
      endcase
   end

   // read data loaded as waitrequest drops, stable at the take edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 32'h0000_0000;
      end else if (wait_ff && avs_read) begin
         rdata_ff <= rd_mux;
      end
   end

   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = wait_ff;

   // ---- core_status ----
   // bank select bits: bus writes and ops aimed at status
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bank_ff <= `CSOR_RST_BANK;
      end else if (exec && dest_st) begin
         // clear op zeroes banks through the result byte
         bank_ff <= st_wr[`CSOR_ST_IRP:`CSOR_ST_RP_LO];
      end else if (wr_lo && avs_address == `CSOR_OFS_STATUS) begin
         bank_ff <= avs_writedata[`CSOR_ST_IRP:`CSOR_ST_RP_LO];
      end
   end

   // indirect half select; direct bank select
   assign indirect_bank_sel = bank_ff[2];
   assign direct_bank_sel   = bank_ff[1:0];

   // watchdog expiry flag, hardware only; a set beats a timeout
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         to_ff <= 1'b1;
      end else if (evt_wdt_clear || evt_sleep) begin
         to_ff <= 1'b1;
      end else if (evt_wdt_timeout) begin
         to_ff <= 1'b0;
      end
      // no bus or op path reaches this flag
   end

   // sleep entered flag, hardware only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pd_ff <= 1'b1;
      end else if (evt_wdt_clear) begin
         pd_ff <= 1'b1;
      end else if (evt_sleep) begin
         pd_ff <= 1'b0;
      end
      // software writes never reach this flag
   end

   // arithmetic flags: op results first, then plain writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // undefined at power-up, zero here for determinism
         flag_ff <= `CSOR_RST_FLAGS;
      end else if (exec && dest_st) begin
         // logic result replaces written flag values
         flag_ff <= st_wr[2:0];
      end else if (exec) begin
         for (int i = 0; i < 3; i++) begin
            if (alu_bus.aff[i]) begin
               flag_ff[i] <= alu_bus.flags[i];
            end
         end
      end else if (wr_lo && avs_address == `CSOR_OFS_STATUS) begin
         // flags are writable when no op is involved
         flag_ff <= avs_writedata[2:0];
      end
   end

   // ---- operand and result registers ----
   // working operand written from the bus
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         work_ff <= `CSOR_RST_WORK;
      end else if (wr_lo && avs_address == `CSOR_OFS_WORK) begin
         work_ff <= avs_writedata[7:0];
      end
   end

   // scratch file: bus write or op result when not aimed at status
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         file_ff <= `CSOR_RST_WORK;
      end else if (exec && !dest_st) begin
         file_ff <= alu_bus.res;
      end else if (wr_lo && avs_address == `CSOR_OFS_FILE) begin
         file_ff <= avs_writedata[7:0];
      end
   end

   // last result, so software sees what the datapath produced
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         result_ff <= `CSOR_RST_WORK;
      end else if (exec) begin
         result_ff <= alu_bus.res;
      end
   end

   // ---- timer_option_config ----
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         option_ff <= `CSOR_RST_OPTION;
      end else if (wr_lo && avs_address == `CSOR_OFS_OPTION) begin
         option_ff <= avs_writedata[7:0];
      end
   end

   // ---- instruction clock ----
   // free running divide by four gives one pulse per four clocks
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_ff <= 2'h0;
      end else begin
         div_ff <= div_ff + 2'h1;
      end
   end
   assign instr_tick = (div_ff == 2'(`CSOR_INSTR_DIV - 1));

   // ---- pin synchronisers ----
   // two flops then a history flop; only stages 1 and 2 feed logic
   // edges wait until the history holds a real sample: no false edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cpin_ff <= 3'h0;
         ipin_ff <= 3'h0;
         arm_ff  <= 3'h0;
      end else begin
         cpin_ff <= {cpin_ff[1:0], counter_input_pin};
         ipin_ff <= {ipin_ff[1:0], ext_irq_pin};
         arm_ff  <= {arm_ff[1:0], 1'b1};
      end
   end

   // falling edge when set, rising when clear
   assign cpin_edge = arm_ff[2] && (option_ff[`CSOR_OPT_EDGE_SEL] ?
                      (cpin_ff[2] && !cpin_ff[1]) :
                      (!cpin_ff[2] && cpin_ff[1]));
   // rising edge when set, falling when clear
   assign irq_edge  = arm_ff[2] && (option_ff[`CSOR_OPT_IRQ_EDGE] ?
                      (!ipin_ff[2] && ipin_ff[1]) :
                      (ipin_ff[2] && !ipin_ff[1]));
   assign src_tick  = option_ff[`CSOR_OPT_CLK_SEL] ? cpin_edge :
                      instr_tick;

   // registered irq edge pulse
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_ev_ff <= 1'b0;
      end else begin
         irq_ev_ff <= irq_edge;
      end
   end
   assign ext_irq_event = irq_ev_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pu_ff <= 8'h00;
      end else if (option_ff[`CSOR_OPT_PU_DIS]) begin
         pu_ff <= 8'h00;
      end else begin
         pu_ff <= pullup_enable_bits;
      end
   end
   assign pullup_en = pu_ff;

   // owner and rate steer the shared prescaler
   csor_prescale #(
      .CNT_W (8)
   ) u_presc (
      .clk      (clk),
      .rst_b    (rst_b),
      .src_tick (src_tick),
      .wdt_tick (wdt_base_tick),
      .owner    (option_ff[`CSOR_OPT_OWNER]),
      .rate     (option_ff[`CSOR_OPT_RATE_HI:`CSOR_OPT_RATE_LO]),
      .cnt_inc  (tick_counter_inc),
      .wdt_out  (watchdog_tick)
   );
endmodule : csor_top
`default_nettype wire

/* rtl/csor_cfg.svh */
// csor register offsets, field positions, reset values and timing counts
`ifndef CSOR_CFG_SVH
`define CSOR_CFG_SVH

// avalon byte offsets, one aligned word per register
`define CSOR_OFS_STATUS    5'h00
`define CSOR_OFS_OPTION    5'h04
`define CSOR_OFS_WORK      5'h08
`define CSOR_OFS_FILE      5'h0c
`define CSOR_OFS_CMD       5'h10
`define CSOR_OFS_RESULT    5'h14

// core_status field positions
`define CSOR_ST_IRP        7
`define CSOR_ST_RP_HI      6
`define CSOR_ST_RP_LO      5
`define CSOR_ST_TO         4
`define CSOR_ST_PD         3
`define CSOR_ST_Z          2
`define CSOR_ST_DC         1
`define CSOR_ST_C          0

// timer_option_config field positions
`define CSOR_OPT_PU_DIS    7
`define CSOR_OPT_IRQ_EDGE  6
`define CSOR_OPT_CLK_SEL   5
`define CSOR_OPT_EDGE_SEL  4
`define CSOR_OPT_OWNER     3
`define CSOR_OPT_RATE_HI   2
`define CSOR_OPT_RATE_LO   0

// command word field positions
`define CSOR_CMD_OP_HI     3
`define CSOR_CMD_DEST      4
`define CSOR_CMD_BIT_HI    7
`define CSOR_CMD_BIT_LO    5
`define CSOR_CMD_LIT_HI    15
`define CSOR_CMD_LIT_LO    8

// reset values
`define CSOR_RST_BANK      3'h0
`define CSOR_RST_FLAGS     3'h0
`define CSOR_RST_OPTION    8'hff
`define CSOR_RST_WORK      8'h00

// instruction cycle is the core clock divided by four
`define CSOR_INSTR_DIV     4

`endif

/* rtl/csor_pkg.sv */
// csor package: datapath operation codes
`default_nettype none
package csor_pkg;
   // instruction datapath operations
   typedef enum logic [3:0] {
      CSOR_OP_ADD_WF,
      CSOR_OP_ADD_LIT,
      CSOR_OP_SUB_WF,
      CSOR_OP_SUB_LIT,
      CSOR_OP_AND,
      CSOR_OP_OR,
      CSOR_OP_XOR,
      CSOR_OP_RRF,
      CSOR_OP_RLF,
      CSOR_OP_FILE_CLEAR_INSTR,
      CSOR_OP_MOVE_FROM_W_INSTR,
      CSOR_OP_NIBBLE_SWAP_INSTR,
      CSOR_OP_BCF,
      CSOR_OP_BSF
   } csor_op_t;
endpackage : csor_pkg
`default_nettype wire

/* rtl/csor_alu_if.sv */
// csor interface between register core and flag datapath
`default_nettype none
interface csor_alu_if;
   import csor_pkg::*;
   logic [7:0] src;     // file operand or literal
   logic [7:0] work;    // working register operand
   csor_op_t   op;      // operation
   logic [2:0] bit_idx; // bit for clear or set
   logic       c_in;    // carry into rotates
   logic [7:0] res;     // result byte
   logic [2:0] flags;   // new z, dc, c
   logic [2:0] aff;     // which flags the op updates
   modport alu  (input src, work, op, bit_idx, c_in,
                 output res, flags, aff);
   modport core (output src, work, op, bit_idx, c_in,
                 input res, flags, aff);
endinterface : csor_alu_if
`default_nettype wire

/* rtl/csor_flag_alu.sv */
// csor flag datapath: result and arithmetic flags of one operation
`default_nettype none
module csor_flag_alu (
   csor_alu_if.alu a
);
   import csor_pkg::*;
   logic [7:0] add_b;   // second addend, inverted for subtraction
   logic       add_ci;  // carry in, one for subtraction
   logic [8:0] sum;     // full sum with carry out
   logic [4:0] nib;     // low nibble sum with digit carry

   always_comb begin
      add_b  = a.work;
      add_ci = 1'b0;
      if (a.op == CSOR_OP_SUB_WF || a.op == CSOR_OP_SUB_LIT) begin
         add_b  = ~a.work;
         add_ci = 1'b1;
      end
      sum = {1'b0, a.src} + {1'b0, add_b} + {8'h00, add_ci};
      nib = {1'b0, a.src[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_ci};
   end

   // per operation result and flag selection
   always_comb begin
      a.res   = a.src;
      a.flags = 3'h0;
      a.aff   = 3'h0;
      unique case (a.op)
         // digit carry out; carry out; borrow is inverted
         CSOR_OP_ADD_WF, CSOR_OP_ADD_LIT,
         CSOR_OP_SUB_WF, CSOR_OP_SUB_LIT: begin
            a.res   = sum[7:0];
            a.flags = {sum[7:0] == 8'h00, nib[4], sum[8]};
            a.aff   = 3'h7;
         end
         CSOR_OP_AND: begin
            a.res = a.src & a.work;
            a.aff = 3'h4;
         end
         CSOR_OP_OR: begin
            a.res = a.src | a.work;
            a.aff = 3'h4;
         end
         CSOR_OP_XOR: begin
            a.res = a.src ^ a.work;
            a.aff = 3'h4;
         end
         CSOR_OP_RRF: begin
            a.res   = {a.c_in, a.src[7:1]};
            a.flags = {2'h0, a.src[0]};
            a.aff   = 3'h1;
         end
         CSOR_OP_RLF: begin
            a.res   = {a.src[6:0], a.c_in};
            a.flags = {2'h0, a.src[7]};
            a.aff   = 3'h1;
         end
         CSOR_OP_FILE_CLEAR_INSTR: begin
            a.res = 8'h00;
            a.aff = 3'h4;
         end
         // moves, swaps and bit ops leave every flag alone
         CSOR_OP_MOVE_FROM_W_INSTR: a.res = a.work;
         CSOR_OP_NIBBLE_SWAP_INSTR: a.res = {a.src[3:0], a.src[7:4]};
         CSOR_OP_BCF:   a.res = a.src & ~(8'h01 << a.bit_idx);
         CSOR_OP_BSF:   a.res = a.src | (8'h01 << a.bit_idx);
         default:       a.res = a.src;  // undefined code: no change
      endcase
      if (a.aff[2]) begin
         a.flags[2] = (a.res == 8'h00);
      end
   end
endmodule : csor_flag_alu
`default_nettype wire

/* rtl/csor_prescale.sv */
// csor shared prescaler between tick counter and watchdog
`default_nettype none
module csor_prescale #(
   parameter int CNT_W = 8  // prescaler counter width
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       src_tick,   // counter source pulse
   input  wire logic       wdt_tick,   // watchdog base pulse
   input  wire logic       owner,      // 1: watchdog, 0: tick counter
   input  wire logic [2:0] rate,       // division select
   output logic            cnt_inc,    // tick counter increment pulse
   output logic            wdt_out     // watchdog increment pulse
);
   logic [CNT_W-1:0] cnt_ff;     // shared divider chain
   logic [CNT_W:0]   tmr_mask;   // 2^(rate+1)-1
   logic [CNT_W:0]   wdt_mask;   // 2^rate-1
   logic [CNT_W:0]   mask;       // mask of the assigned user
   logic             in_tick;    // pulse fed into the chain
   logic             fire;       // divided pulse

   always_comb begin
      // shift amount one bit wider so rate seven reaches 1:256
      tmr_mask = ({{CNT_W{1'b0}}, 1'b1} << ({1'b0, rate} + 4'h1)) - 1'b1;
      wdt_mask = ({{CNT_W{1'b0}}, 1'b1} << rate) - 1'b1;
      mask     = owner ? wdt_mask : tmr_mask;
      in_tick  = owner ? wdt_tick : src_tick;
      fire     = in_tick && ((cnt_ff & mask[CNT_W-1:0]) ==
                             mask[CNT_W-1:0]);
   end

   // divider chain advances only on its own input pulse
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= '0;
      end else if (in_tick) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // owner high gives tick counter undivided source
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_inc <= 1'b0;
         wdt_out <= 1'b0;
      end else begin
         cnt_inc <= owner ? src_tick : fire;
         wdt_out <= owner ? fire : wdt_tick;
      end
   end
endmodule : csor_prescale
`default_nettype wire

/* tb/csor_monitor.sv */
// csor checker: bus timing and register-driven outputs
`include "csor_cfg.svh"
`default_nettype none
module csor_monitor (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        wdt_base_tick,
   input wire logic [7:0]  pullup_enable_bits,
   input wire logic [7:0]  pullup_en,
   input wire logic        tick_counter_inc,
   input wire logic        watchdog_tick,
   input wire logic [1:0]  direct_bank_sel,
   input wire logic        indirect_bank_sel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [7:0] opt_ff;  // shadow of the option register
   logic       take;    // accepted write this edge
   assign take = avs_write & ~avs_waitrequest & avs_byteenable[0];
   // shadow copies accepted option writes so outputs can be predicted
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) opt_ff <= 8'hff;
      else if (take && avs_address == `CSOR_OFS_OPTION)
         opt_ff <= avs_writedata[7:0];
   end
   sequence s_req; (avs_read | avs_write) && avs_waitrequest; endsequence
   sequence s_gap;
      tick_counter_inc && opt_ff[5:3] == 3'b001
      ##1 (opt_ff[5:3] == 3'b001 && !tick_counter_inc) [*3];
   endsequence
   property p_answer; s_req |=> !avs_waitrequest; endproperty
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   property p_idle;
      !(avs_read | avs_write) && avs_waitrequest |=> avs_waitrequest;
   endproperty
   property p_rdhi;
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
   endproperty
   property p_bank;
      take && avs_address == `CSOR_OFS_STATUS |=>
         {indirect_bank_sel, direct_bank_sel} == $past(avs_writedata[7:5]);
   endproperty
   property p_pullup;
      pullup_en == ($past(opt_ff[7]) ? 8'h00 : $past(pullup_enable_bits));
   endproperty
   property p_wdt;
      !opt_ff[3] && !$past(opt_ff[3]) |-> watchdog_tick == $past(wdt_base_tick);
   endproperty
   property p_inst; s_gap |=> tick_counter_inc; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   a_one: assert property (p_one) else $error("long answer");
   a_idle: assert property (p_idle) else $error("stray answer");
   a_rdhi: assert property (p_rdhi) else $error("upper bits set");
   a_bank: assert property (p_bank) else $error("bank select");
   a_pullup: assert property (p_pullup) else $error("pull-up");
   a_wdt: assert property (p_wdt) else $error("watchdog pass");
   a_inst: assert property (p_inst) else $error("counter rate");
endmodule : csor_monitor
bind csor_top csor_monitor csor_monitor_i (.clk, .rst_b, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .wdt_base_tick, .pullup_enable_bits, .pullup_en,
   .tick_counter_inc, .watchdog_tick, .direct_bank_sel, .indirect_bank_sel);
`default_nettype wire

/* tb/csor_top_tb.sv */
// csor testbench: register bus scenarios with expected values
`include "csor_cfg.svh"
`default_nettype none
module csor_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  be = 4'h1;
   logic [2:0]  evt = 3'h0;   // clear, sleep, timeout
   logic        base = 1'b1;  // watchdog base ticks every cycle
   logic [7:0]  pu_bits = 8'ha5;
   logic [31:0] rdat;
   logic        wait_req;
   logic [7:0]  pu_en;
   logic        cinc;
   logic        wtick;
   logic        irq_ev;
   logic [1:0]  pin = 2'h0;   // counter pin, irq pin
   int          ev_n = 0;     // irq event pulses seen
   int          ci_n = 0;     // counter increments seen
   int          e0;
   int          c0;
   logic [7:0]  v;            // last read byte
   int          n;
   int          fails = 0;
   int          samples_checked = 0;
   // op, work, file, literal, result, flags z dc c
   logic [38:0] tab [8] = '{
      {4'h0, 8'h0f, 8'h01, 8'h00, 8'h10, 3'h2},
      {4'h0, 8'hff, 8'h01, 8'h00, 8'h00, 3'h7},
      {4'h2, 8'h03, 8'h05, 8'h00, 8'h02, 3'h3},
      {4'h2, 8'h05, 8'h03, 8'h00, 8'hfe, 3'h0},
      {4'h1, 8'h80, 8'h00, 8'h80, 8'h00, 3'h5},
      {4'h3, 8'h01, 8'h00, 8'h10, 8'h0f, 3'h1},
      {4'h7, 8'h00, 8'h80, 8'h00, 8'hc0, 3'h0},
      {4'h8, 8'h00, 8'h81, 8'h00, 8'h02, 3'h1}};
   always #5 clk = ~clk;
   // pulse counters for the pin edge scenario
   always @(posedge clk) begin
      if (irq_ev === 1'b1) ev_n <= ev_n + 1;
      if (cinc === 1'b1) ci_n <= ci_n + 1;
   end
   csor_top csor_top_i (.clk(clk), .rst_b(rst_b), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
      .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_req),
      .evt_wdt_clear(evt[2]), .evt_sleep(evt[1]), .evt_wdt_timeout(evt[0]),
      .wdt_base_tick(base), .pullup_enable_bits(pu_bits),
      .counter_input_pin(pin[1]), .ext_irq_pin(pin[0]), .pullup_en(pu_en),
      .ext_irq_event(irq_ev), .tick_counter_inc(cinc), .watchdog_tick(wtick),
      .direct_bank_sel(), .indirect_bank_sel());
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   // one bus access, held until waitrequest is sampled low
   task automatic xfer(input logic w, input logic [4:0] a,
                       input logic [15:0] d);
      int k;
      k = 0;
      @(posedge clk);
      adr <= a;
      wdat <= {16'h0, d};
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         k++;
      end while (wait_req !== 1'b0 && k < 50);
      v = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      if (k >= 50) begin
         fails++;
         tally_and_finish();
      end
   endtask : xfer
   task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
      xfer(1'b0, a, 16'h0);
      check(v, e);
   endtask : rd_chk
   task automatic pulse(input logic [2:0] e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= 3'h0;
   endtask : pulse
   // skip two pulses, then count cycles from the second pulse to the third
   task automatic gap(input logic s);
      int k;
      k = 0;
      n = 0;
      repeat (2) begin
         do begin
            @(posedge clk);
            k++;
         end while ((s ? wtick : cinc) !== 1'b1 && k < 600);
      end
      do begin
         @(posedge clk);
         n++;
      end while ((s ? wtick : cinc) !== 1'b1 && n < 300);
      // a pulse that never comes ends the run as a failure
      if (k >= 600 || n >= 300) begin
         fails++;
         tally_and_finish();
      end
   endtask : gap
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk(`CSOR_OFS_STATUS, 8'h18);
      rd_chk(`CSOR_OFS_OPTION, 8'hff);
      xfer(1'b1, `CSOR_OFS_STATUS, 16'h00);
      rd_chk(`CSOR_OFS_STATUS, 8'h18);
      xfer(1'b1, `CSOR_OFS_STATUS, 16'he7);
      rd_chk(`CSOR_OFS_STATUS, 8'hff);
      xfer(1'b1, `CSOR_OFS_CMD, 16'h0019);
      rd_chk(`CSOR_OFS_STATUS, 8'h1f);
      pulse(3'h2);
      rd_chk(`CSOR_OFS_STATUS, 8'h17);
      pulse(3'h1);
      rd_chk(`CSOR_OFS_STATUS, 8'h07);
      pulse(3'h4);
      rd_chk(`CSOR_OFS_STATUS, 8'h1f);
      foreach (tab[i]) begin
         xfer(1'b1, `CSOR_OFS_WORK, {8'h0, tab[i][34:27]});
         xfer(1'b1, `CSOR_OFS_FILE, {8'h0, tab[i][26:19]});
         xfer(1'b1, `CSOR_OFS_CMD, {tab[i][18:11], 4'h0, tab[i][38:35]});
         rd_chk(`CSOR_OFS_RESULT, tab[i][10:3]);
         xfer(1'b0, `CSOR_OFS_STATUS, 16'h0);
         check({5'h0, v[2:0]}, {5'h0, tab[i][2:0]});
      end
      // refused accesses leave registers alone
      xfer(1'b1, 5'h1c, 16'hff);
      rd_chk(5'h1c, 8'h00);
      be <= 4'h0;
      xfer(1'b1, `CSOR_OFS_OPTION, 16'h5a);
      be <= 4'h1;
      rd_chk(`CSOR_OFS_OPTION, 8'hff);
      xfer(1'b1, `CSOR_OFS_OPTION, 16'h08);
      rd_chk(`CSOR_OFS_OPTION, 8'h08);
      check(pu_en, 8'ha5);
      gap(1'b0);
      check(n[7:0], 8'h04);
      for (int r = 0; r < 3; r++) begin
         xfer(1'b1, `CSOR_OFS_OPTION, 16'h80 | 16'(r));
         gap(1'b0);
         check(n[7:0], 8'h08 << r);
         check(pu_en, 8'h00);
      end
      xfer(1'b1, `CSOR_OFS_OPTION, 16'h0f);
      gap(1'b1);
      check(n[7:0], 8'h80);
      for (int m = 0; m < 2; m++) begin
         xfer(1'b1, `CSOR_OFS_OPTION, m ? 16'h38 : 16'h68);
         repeat (6) @(posedge clk);
         e0 = ev_n;
         c0 = ci_n;
         // three rises and two falls
         repeat (5) begin
            pin <= ~pin;
            repeat (6) @(posedge clk);
         end
         check(8'(ev_n - e0), 8'h03 - 8'(m));
         check(8'(ci_n - c0), 8'h03 - 8'(m));
         pin <= 2'h0;
         repeat (6) @(posedge clk);
      end
      tally_and_finish();
   end
endmodule : csor_top_tb
`default_nettype wire
